// ==== verif/prog_model.sv ====
/*
  Behavioural programmer on the far side of the programming link.
  Assumes the bench ties its pins to the entry block and reads the data pin back.
*/
`timescale 1ns/1ns
module prog_model (
  // link pins toward the device
  output logic serial_clock,
  output logic serial_data,
  output logic reset_pin,
  output logic high_voltage
);
  // ****************************************
  // idle levels
  // ****************************************
  // link clock stands low outside frames
  initial
  begin
    serial_clock = 1'b0;
    serial_data = 1'b0;
    reset_pin = 1'b1;
    high_voltage = 1'b0;
  end

  task automatic shift_out(input logic [31:0] value, input int nbits);
    for (int i = nbits - 1; i >= 0; i--)
    begin
      serial_data = value[i];
      #40 serial_clock = 1'b1;
      #40 serial_clock = 1'b0;
    end
    // released line shows the inverse, not a stale level
    serial_data = ~serial_data;
  endtask : shift_out

  // reset low first, key bits follow
  task automatic lv_start();
    reset_pin = 1'b0;
    #100;
  endtask : lv_start

  // full key entry after reset goes low
  task automatic lv_enter(input logic [31:0] key);
    lv_start();
    shift_out(key, 32);
  endtask : lv_enter

  // clock and data low before high voltage
  task automatic hv_enter();
    serial_clock = 1'b0;
    serial_data = 1'b0;
    #100 high_voltage = 1'b1;
  endtask : hv_enter

  // end of session
  task automatic leave();
    reset_pin = 1'b1;
    high_voltage = 1'b0;
    #100;
  endtask : leave
endmodule : prog_model

// ==== verif/serial_programming_entry_test.sv ====
/*
  Self-checking bench for the programming entry block.
  Assumes the programmer model drives the link pins at an 80 ns link period.
*/
`timescale 1ns/1ns
`define CHK(a, b) \
  begin \
    n_compared++; \
    if ((a) !== (b)) \
    begin \
      n_errors++; \
      $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); \
    end \
  end
module serial_programming_entry_test;
  import prog_entry_pkg::*;
  localparam logic [31:0] TEST_KEY = 32'h5a3c96e1;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic sclk, mdata, rst_pin, hv, data_out, oe, lv_en, cfg, rx_valid, rx_ready;
  logic rpf, pv_mode, hv_sess, clr_ok;
  logic tx_valid, tx_val;
  wire logic data_pin;
  prog_byte_t rx_byte;
  int n_errors = 0;
  int n_compared = 0;

  // data pin level from both drivers
  assign data_pin = oe ? data_out : mdata;

  prog_model pm (.serial_clock(sclk), .serial_data(mdata), .reset_pin(rst_pin),
    .high_voltage(hv));

  serial_programming_entry uut (.clock(clock), .reset(reset), .prog_serial_clock(sclk),
    .prog_serial_data_in(data_pin), .prog_serial_data_out(data_out),
    .prog_serial_data_oe(oe), .master_clear_reset_pin(rst_pin),
    .high_programming_voltage_level(hv), .low_voltage_prog_enable(lv_en),
    .reset_pin_function_cfg(cfg), .expected_key(TEST_KEY), .reset_pin_function(rpf),
    .program_verify_mode(pv_mode), .hv_session(hv_sess), .clear_lv_enable_ok(clr_ok),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_byte(rx_byte), .tx_bit_valid(tx_valid),
    .tx_bit(tx_val));

  // ****************************************
  // clock and closing
  // ****************************************
  initial
  begin
    forever #5 clock = ~clock;
  end

  task automatic print_verdict();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : wait_cyc

  // take one byte from the receive side, bounded wait
  task automatic take(input logic [7:0] d, input logic from_hv);
    int n;
    n = 0;
    while (rx_valid !== 1'b1 && n < 200)
    begin
      @(negedge clock);
      n++;
    end
    `CHK(rx_valid, 1'b1)
    `CHK(rx_byte, {d, from_hv})
    rx_ready = 1'b1;
    @(negedge clock);
    rx_ready = 1'b0;
    // let an edge pass so a following call never re-raises ready in this step
    @(negedge clock);
  endtask : take

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_lv_entry();
    pm.lv_enter(TEST_KEY);
    wait_cyc(10);
    `CHK(pv_mode, 1'b1)
    `CHK({hv_sess, clr_ok}, 2'b00)
    pm.shift_out(32'ha5, 8);
    take(8'ha5, 1'b0);
    pm.leave();
    `CHK(pv_mode, 1'b0)
    $display("lv entry done");
  endtask : t_lv_entry

  task automatic t_refused();
    pm.lv_enter(TEST_KEY ^ 32'h1);
    wait_cyc(10);
    `CHK(pv_mode, 1'b0)
    pm.leave();
    lv_en = 1'b0;
    pm.lv_enter(TEST_KEY);
    wait_cyc(10);
    `CHK(pv_mode, 1'b0)
    pm.leave();
    lv_en = 1'b1;
    // half a key, early release, then a full key must still enter
    pm.lv_start();
    pm.shift_out(TEST_KEY >> 16, 16);
    pm.leave();
    `CHK(pv_mode, 1'b0)
    pm.lv_enter(TEST_KEY);
    wait_cyc(10);
    `CHK(pv_mode, 1'b1)
    pm.leave();
    $display("refused entries done");
  endtask : t_refused

  task automatic t_hv_fifo();
    pm.hv_enter();
    wait_cyc(10);
    `CHK({pv_mode, hv_sess, clr_ok}, 3'b111)
    `CHK(oe, 1'b0)
    // five bytes while the core stalls: four in the fifo, one in the output stage
    for (int i = 1; i <= 5; i++)
      pm.shift_out(32'(i * 17), 8);
    wait_cyc(10);
    for (int i = 1; i <= 5; i++)
      take(8'(i * 17), 1'b1);
    rx_ready = 1'b1;
    wait_cyc(40);
    rx_ready = 1'b0;
    `CHK(rx_valid, 1'b0)
    // one low bit driven back at the next link fall, against a high line
    tx_valid = 1'b1;
    tx_val = 1'b0;
    pm.shift_out(32'h0, 1);
    wait_cyc(5);
    `CHK({oe, data_pin}, 2'b10)
    tx_valid = 1'b0;
    pm.leave();
    `CHK(pv_mode, 1'b0)
    `CHK(oe, 1'b0)
    $display("hv and buffer done");
  endtask : t_hv_fifo

  task automatic t_reset_fn();
    for (int i = 0; i < 4; i++)
    begin
      lv_en = i[1];
      cfg = i[0];
      wait_cyc(3);
      `CHK(rpf, i[1] | i[0])
    end
    lv_en = 1'b1;
    $display("reset function done");
  endtask : t_reset_fn

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    lv_en = 1'b1;
    cfg = 1'b0;
    rx_ready = 1'b0;
    tx_valid = 1'b0;
    tx_val = 1'b0;
    wait_cyc(3);
    `CHK({rpf, pv_mode, oe, rx_valid}, 4'b1000)
    wait_cyc(3);
    reset = 1'b0;
    wait_cyc(5);
    t_lv_entry();
    t_refused();
    t_hv_fifo();
    t_reset_fn();
    print_verdict();
  end

  initial
  begin
    #400000;
    n_errors++;
    print_verdict();
  end
endmodule : serial_programming_entry_test

// ==== verilog/byte_fifo.sv ====
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] fill;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // full and empty come from the occupancy count
  assign fill = wr_ptr - rd_ptr;
  assign in_ready = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data = mem[rd_ptr[AW-1:0]];

  // pointers
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // storage, no reset needed on data
  always_ff @(posedge clock)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end

endmodule : byte_fifo

// ==== verilog/prog_entry_pkg.sv ====
/*
  Shared constants and carrier types for the serial programming entry block.
  Assumes a 100 MHz core clock and a programmer-driven link clock far slower.
*/
package prog_entry_pkg;

  // ****************************************
  // key and link figures
  // ****************************************
  localparam int KEY_BITS = 32;
  localparam logic [31:0] KEY_RESET = 32'h00000000;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 4;
  localparam logic [5:0] COUNT_RESET = 6'h00;

  // ****************************************
  // entry states, one-hot
  // ****************************************
  typedef enum logic [3:0] {
    st_run = 4'h1,
    st_shift = 4'h2,
    st_lv_prog = 4'h4,
    st_hv_prog = 4'h8
  } entry_state_t;

  // pins as sampled by the core clock
  typedef struct packed {
    logic serial_clock;
    logic serial_data;
    logic reset_pin_low;
    logic high_voltage;
  } pin_sample_t;

  // one received programming byte
  typedef struct packed {
    logic [7:0] data;
    logic from_hv;
  } prog_byte_t;

endpackage : prog_entry_pkg

// ==== verilog/serial_programming_entry.sv ====
/*
  Entry logic for the in-circuit serial programming port: high-voltage and
  key-sequence entry into program/verify mode, and a byte receiver for the
  programming link. Assumes all pins are asynchronous to clock and that the
  link clock is much slower than the core clock.
*/
// Function
// - The serial clock is only an input and the serial data pin is two-way.
// - Programming data is taken only over the serial link during program/verify mode.
// - Key entry works only while the low-voltage enable bit is 1.
// - Clearing the low-voltage enable bit is accepted only in a high-voltage session.
// - After the key the mode holds only while reset stays low.
// - A set low-voltage enable bit forces the reset-pin function on.
`timescale 1ns/1ns
module serial_programming_entry (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // programming pins
  input wire logic prog_serial_clock,
  input wire logic prog_serial_data_in,
  output logic prog_serial_data_out,
  output logic prog_serial_data_oe,
  input wire logic master_clear_reset_pin,
  input wire logic high_programming_voltage_level,
  // configuration
  input wire logic low_voltage_prog_enable,
  input wire logic reset_pin_function_cfg,
  input wire logic [31:0] expected_key,
  // core side
  output logic reset_pin_function,
  output logic program_verify_mode,
  output logic hv_session,
  output logic clear_lv_enable_ok,
  output logic rx_valid,
  input wire logic rx_ready,
  output prog_entry_pkg::prog_byte_t rx_byte,
  input wire logic tx_bit_valid,
  input wire logic tx_bit
);
  import prog_entry_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  pin_sample_t sync_a;
  pin_sample_t sync_b;
  logic clock_prev;

  // two stages per pin; only sync_b is read
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= '{prog_serial_clock, prog_serial_data_in, ~master_clear_reset_pin,
                  high_programming_voltage_level};
      sync_b <= sync_a;
    end
  end

  // rising and falling edges of the link clock as seen by the core clock
  always_ff @(posedge clock)
  begin
    if (reset)
      clock_prev <= 1'b0;
    else
      clock_prev <= sync_b.serial_clock;
  end

  wire link_rise = sync_b.serial_clock && !clock_prev;
  wire link_fall = !sync_b.serial_clock && clock_prev;

  // ****************************************
  // entry state machine
  // ****************************************
  entry_state_t state;
  entry_state_t next_state;
  logic [31:0] key_shift;
  logic [5:0] key_count;

  wire hv_entry = sync_b.high_voltage && !sync_b.serial_clock && !sync_b.serial_data;
  wire key_full = (key_count == 6'(KEY_BITS));
  wire key_match = (key_shift == expected_key);
  wire in_prog = (state == st_lv_prog) || (state == st_hv_prog);

  // next state decode
  always_comb
  begin
    next_state = state;
    case (state)
      st_run:
        if (hv_entry)
          next_state = st_hv_prog;
        else if (low_voltage_prog_enable && sync_b.reset_pin_low)
          next_state = st_shift;
      st_shift:
        if (hv_entry)
          next_state = st_hv_prog;
        else if (!sync_b.reset_pin_low || !low_voltage_prog_enable)
          next_state = st_run;
        else if (key_full)
          next_state = key_match ? st_lv_prog : st_run;
      st_lv_prog:
        if (!sync_b.reset_pin_low)
          next_state = st_run;
      st_hv_prog:
        if (!sync_b.high_voltage)
          next_state = st_run;
      default:
        next_state = st_run;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      state <= st_run;
    else
      state <= next_state;
  end

  // key shifter cleared while reset pin is high
  always_ff @(posedge clock)
  begin
    if (reset || !sync_b.reset_pin_low || state != st_shift)
    begin
      key_shift <= KEY_RESET;
      key_count <= COUNT_RESET;
    end
    else if (link_rise && !key_full)
    begin
      // msb first shift on rising link clock
      key_shift <= {key_shift[30:0], sync_b.serial_data};
      key_count <= key_count + 6'h01;
    end
  end

  // ****************************************
  // programming byte receiver
  // ****************************************
  logic [7:0] rx_shift;
  logic [3:0] rx_count;
  logic push_valid;
  logic fifo_in_ready;
  prog_byte_t push_byte;
  prog_byte_t fifo_out;
  logic fifo_out_valid;
  logic pop;

  // data only collected in program/verify mode
  always_ff @(posedge clock)
  begin
    if (reset || !in_prog)
    begin
      rx_shift <= 8'h00;
      rx_count <= 4'h0;
      push_valid <= 1'b0;
      push_byte <= '0;
    end
    else
    begin
      if (push_valid && fifo_in_ready)
        push_valid <= 1'b0;
      // stall: hold the link bit count at 8 while the previous byte still waits to enter the fifo
      if (link_rise && rx_count != 4'h8)
      begin
        rx_shift <= {rx_shift[6:0], sync_b.serial_data};
        rx_count <= rx_count + 4'h1;
      end
      else if (rx_count == 4'h8 && !push_valid)
      begin
        push_byte <= '{rx_shift, state == st_hv_prog};
        push_valid <= 1'b1;
        rx_count <= 4'h0;
      end
    end
  end

  byte_fifo #(
    .WIDTH(FIFO_WIDTH + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset(reset || !in_prog),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_byte),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out)
  );

  // registered output stage: load when empty or being taken
  assign pop = fifo_out_valid && (!rx_valid || rx_ready);

  always_ff @(posedge clock)
  begin
    if (reset || !in_prog)
    begin
      rx_valid <= 1'b0;
      rx_byte <= '0;
    end
    else if (pop)
    begin
      rx_valid <= 1'b1;
      rx_byte <= fifo_out;
    end
    else if (rx_ready)
      rx_valid <= 1'b0;
  end

  // ****************************************
  // data pin drive and status outputs
  // ****************************************
  // data pin driven back only on falling link clock in prog mode
  always_ff @(posedge clock)
  begin
    if (reset || !in_prog)
    begin
      prog_serial_data_out <= 1'b0;
      prog_serial_data_oe <= 1'b0;
    end
    else if (link_fall)
    begin
      prog_serial_data_out <= tx_bit;
      prog_serial_data_oe <= tx_bit_valid;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      reset_pin_function <= 1'b1;
      program_verify_mode <= 1'b0;
      hv_session <= 1'b0;
      clear_lv_enable_ok <= 1'b0;
    end
    else
    begin
      // enable bit forces reset pin on
      reset_pin_function <= low_voltage_prog_enable || reset_pin_function_cfg;
      program_verify_mode <= (next_state == st_lv_prog) || (next_state == st_hv_prog);
      hv_session <= (next_state == st_hv_prog);
      // clearing enable bit only in high-voltage session
      clear_lv_enable_ok <= (next_state == st_hv_prog);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_lv_gate_off: assert property (@(posedge clock) disable iff (reset)
    (state == st_run && !low_voltage_prog_enable && !hv_entry) |=> state == st_run)
    else $error("key path entered with enable bit clear");
  a_reset_func_on: assert property (@(posedge clock) disable iff (reset)
    low_voltage_prog_enable |=> reset_pin_function)
    else $error("reset pin function not forced");
  a_clear_hv_only: assert property (@(posedge clock) disable iff (reset)
    clear_lv_enable_ok |-> $past(state) == st_hv_prog || state == st_hv_prog)
    else $error("enable clear allowed outside high-voltage session");
  a_lv_hold_low: assert property (@(posedge clock) disable iff (reset)
    (state == st_lv_prog && !sync_b.reset_pin_low) |=> !in_prog)
    else $error("low-voltage mode kept after reset release");
  a_key_mismatch: assert property (@(posedge clock) disable iff (reset)
    (state == st_shift && key_full && !key_match && !hv_entry) |=> state == st_run)
    else $error("entry despite key mismatch");
  a_key_clear: assert property (@(posedge clock) disable iff (reset)
    !sync_b.reset_pin_low |=> key_count == COUNT_RESET)
    else $error("key count not cleared");
  a_rx_prog_only: assert property (@(posedge clock) disable iff (reset)
    rx_valid |-> $past(in_prog))
    else $error("byte delivered outside programming mode");
  a_oe_prog_only: assert property (@(posedge clock) disable iff (reset)
    prog_serial_data_oe |-> $past(in_prog))
    else $error("data pin driven outside programming mode");
  a_mode_flag: assert property (@(posedge clock) disable iff (reset)
    program_verify_mode == in_prog)
    else $error("mode output disagrees with state");

  c_lv_entry: cover property (@(posedge clock) state == st_shift ##1 state == st_lv_prog);
  c_hv_entry: cover property (@(posedge clock) state == st_run ##1 state == st_hv_prog);
  c_abandon: cover property (@(posedge clock) state == st_shift ##1 state == st_run);
  c_byte_out: cover property (@(posedge clock) rx_valid && rx_ready);

endmodule : serial_programming_entry
